// >>> core/module_power_reset_status.sv
/*
  Module end: measures control pin pulses in milliseconds and sequences
  power-on, shutdown and reset, and drives the link state indicator.
  Assumes pins are asynchronous to sys_clk and a 50 MHz clock.
*/
`timescale 1ns/1ps
module module_power_reset_status #(
  parameter int MS_CYCLES = pwr_seq_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control pins
  pwr_ctrl_if.device pins,
  // Firmware side
  input wire logic soft_reset_cmd,
  input wire logic soft_shutdown_cmd,
  input wire pwr_seq_pkg::ind_mode_t ind_mode,
  output logic powered,
  output logic ready,
  output logic in_reset
);
  import pwr_seq_pkg::*;

  if (MS_CYCLES < 1) begin : g_bad_cycles
    $error("MS_CYCLES must be at least 1");
  end

  typedef enum logic [2:0] {
    ST_OFF,
    ST_BOOT,
    ST_ON,
    ST_RESET,
    ST_SHUTDOWN
  } pwr_state_t;

  // ****************************************
  // Pin synchronisers and millisecond tick
  // ****************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic key_low;
  logic level_high;
  logic rst_low;
  logic [31:0] ms_div;
  logic ms_tick;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else begin
      sync_a <= {pins.power_key_line_n, ~pins.power_on_level_line, pins.reset_line_n};
      sync_b <= sync_a;
    end
  end
  assign key_low = ~sync_b[2];
  assign level_high = ~sync_b[1];
  assign rst_low = ~sync_b[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ms_div <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == 32'(MS_CYCLES - 1));
      ms_div <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div + 32'h1;
    end
  end

  // ****************************************
  // Pulse length counters
  // ****************************************
  logic [MS_W-1:0] key_ms;
  logic [MS_W-1:0] level_ms;
  logic [MS_W-1:0] rst_ms;
  logic key_low_d;
  logic rst_low_d;
  logic key_release;
  logic rst_release;

  function automatic logic [MS_W-1:0] count_up(input logic active, input logic tick,
                                              input logic [MS_W-1:0] cnt);
    if (!active) return '0;
    if (tick && cnt != {MS_W{1'b1}}) return cnt + 1'b1;
    return cnt;
  endfunction

  function automatic logic in_window(input logic [MS_W-1:0] cnt, input int lo, input int hi);
    return (cnt >= MS_W'(lo)) && (cnt <= MS_W'(hi));
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_ms <= '0;
      level_ms <= '0;
      rst_ms <= '0;
      key_low_d <= 1'b0;
      rst_low_d <= 1'b0;
    end else begin
      key_ms <= count_up(key_low, ms_tick, key_ms);
      level_ms <= count_up(level_high, ms_tick, level_ms);
      rst_ms <= count_up(rst_low, ms_tick, rst_ms);
      key_low_d <= key_low;
      rst_low_d <= rst_low;
    end
  end
  assign key_release = key_low_d && !key_low;
  assign rst_release = rst_low_d && !rst_low;

  // ****************************************
  // Power state sequencer
  // ****************************************
  pwr_state_t state;
  logic [MS_W-1:0] wait_ms;
  logic was_soft_off;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_OFF;
      wait_ms <= '0;
      was_soft_off <= 1'b0;
    end else begin
      if (ms_tick && wait_ms != '0) wait_ms <= wait_ms - 1'b1;
      unique case (state)
        ST_OFF: begin
          // A soft shutdown is undone by any key low; timing ignored
          if ((key_release && in_window(key_ms, KEY_ON_MIN_MS, KEY_ON_MAX_MS))
              || (was_soft_off && key_low)) begin
            state <= ST_BOOT;
            wait_ms <= MS_W'(BOOT_MS);
            was_soft_off <= 1'b0;
          end else if (level_ms > MS_W'(LEVEL_ON_MIN_MS)) begin
            state <= ST_BOOT;
            wait_ms <= MS_W'(BOOT_MS);
          end
        end
        ST_BOOT, ST_RESET: begin
          // Pins are ignored until start-up has finished
          if (wait_ms == '0) state <= ST_ON;
        end
        ST_ON: begin
          if (key_release && in_window(key_ms, KEY_OFF_MIN_MS, KEY_OFF_MAX_MS)) begin
            state <= ST_SHUTDOWN;
            wait_ms <= MS_W'(SHUTDOWN_MS);
          end else if (soft_shutdown_cmd) begin
            state <= ST_SHUTDOWN;
            wait_ms <= MS_W'(SHUTDOWN_MS);
            was_soft_off <= 1'b1;
          end else if ((rst_release && in_window(rst_ms, RESET_MIN_MS, RESET_MAX_MS))
                       || soft_reset_cmd) begin
            state <= ST_RESET;
            wait_ms <= MS_W'(BOOT_MS);
          end
        end
        ST_SHUTDOWN: begin
          if (wait_ms == '0) state <= ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powered <= 1'b0;
      ready <= 1'b0;
      in_reset <= 1'b0;
      pins.io_rail_output <= 1'b0;
    end else begin
      powered <= (state != ST_OFF);
      ready <= (state == ST_ON);
      in_reset <= (state == ST_RESET);
      pins.io_rail_output <= (state != ST_OFF);
    end
  end

  // ****************************************
  // Link state indicator
  // ****************************************
  logic [MS_W-1:0] blink_ms;
  logic blink_lvl;
  ind_mode_t mode_d;

  function automatic logic [MS_W-1:0] phase_len(input ind_mode_t m, input logic lvl);
    unique case (m)
      IND_SEARCH: return MS_W'(BLINK_SLOW_MS);
      IND_STANDBY: return lvl ? MS_W'(BLINK_LONG_MS) : MS_W'(BLINK_SHORT_MS);
      IND_DATA: return MS_W'(BLINK_SHORT_MS);
      IND_VOICE: return MS_W'(1);
    endcase
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blink_ms <= '0;
      blink_lvl <= 1'b0;
      mode_d <= IND_SEARCH;
      pins.link_state_indicator <= 1'b0;
    end else begin
      mode_d <= ind_mode;
      if (state != ST_ON || ind_mode == IND_VOICE) begin
        blink_lvl <= 1'b0;
        blink_ms <= '0;
      end else if (ind_mode != mode_d) begin
        // Restart the pattern cleanly on a mode change
        blink_lvl <= (ind_mode != IND_STANDBY);
        blink_ms <= '0;
      end else if (ms_tick) begin
        if (blink_ms + 1'b1 >= phase_len(ind_mode, blink_lvl)) begin
          blink_lvl <= ~blink_lvl;
          blink_ms <= '0;
        end else begin
          blink_ms <= blink_ms + 1'b1;
        end
      end
      pins.link_state_indicator <= blink_lvl;
    end
  end
endmodule

// >>> pkg/pwr_seq_pkg.sv
/*
  Shared constants and types for the module power and reset sequencer:
  timing windows, indicator periods and enumerations.
  Assumes a 50 MHz system clock on both ends.
*/
package pwr_seq_pkg;

  // ****************************************
  // Clock and base tick
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_NS = 1_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CYC_PER_MS = TICK_NS / CLK_PERIOD_NS;

  // ****************************************
  // Times in milliseconds
  // ****************************************
  localparam int KEY_ON_MIN_MS = 1600;
  localparam int KEY_ON_MAX_MS = 3000;
  localparam int KEY_OFF_MIN_MS = 3000;
  localparam int KEY_OFF_MAX_MS = 7000;
  localparam int LEVEL_ON_MIN_MS = 1200;
  localparam int RESET_MIN_MS = 500;
  localparam int RESET_MAX_MS = 3000;
  localparam int SUPPLY_SETTLE_MS = 30;
  localparam int BOOT_MS = 40000;
  localparam int SHUTDOWN_MS = 6000;
  localparam int RESET_GAP_MS = 20000;
  localparam int BLINK_SLOW_MS = 600;
  localparam int BLINK_SHORT_MS = 75;
  localparam int BLINK_LONG_MS = 3000;

  localparam int MS_W = 17;

  typedef enum logic [1:0] {
    IND_SEARCH,
    IND_STANDBY,
    IND_DATA,
    IND_VOICE
  } ind_mode_t;

endpackage

// >>> pkg/pwr_ctrl_if.sv
/*
  Control pins between host controller and module.
  Assumes both ends on sys_clk; the module still synchronises pins.
*/
`timescale 1ns/1ps
interface pwr_ctrl_if;
  logic power_key_line_n;
  logic power_on_level_line;
  logic reset_line_n;
  logic io_rail_output;
  logic link_state_indicator;

  modport device (
    input power_key_line_n,
    input power_on_level_line,
    input reset_line_n,
    output io_rail_output,
    output link_state_indicator
  );

  modport host (
    output power_key_line_n,
    output power_on_level_line,
    output reset_line_n,
    input io_rail_output,
    input link_state_indicator
  );
endinterface

// >>> core/host_power_controller.sv
/*
  Host end: turns one-cycle requests into timed pulses on the module
  control pins and keeps the spacing the module needs.
  Assumes requests come from logic on sys_clk.
*/
`timescale 1ns/1ps
module host_power_controller #(
  parameter int MS_CYCLES = pwr_seq_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Requests
  input wire logic req_power_on,
  input wire logic req_power_off,
  input wire logic req_reset,
  input wire logic level_hold,
  // Status
  output logic busy,
  output logic module_rail_up,
  // Control pins
  pwr_ctrl_if.host pins
);
  import pwr_seq_pkg::*;

  if (MS_CYCLES < 1) begin : g_bad_cycles
    $error("MS_CYCLES must be at least 1");
  end

  // Pulse lengths picked mid-window for margin
  localparam int KEY_ON_HOLD_MS = 2000;
  localparam int KEY_OFF_HOLD_MS = 5000;
  localparam int RESET_HOLD_MS = 1000;
  // Slack over the module's own wait, whose ms count may lag a tick
  localparam int GAP_MARGIN_MS = 2;

  typedef enum logic [1:0] {
    H_SETTLE,
    H_IDLE,
    H_PULSE,
    H_WAIT
  } host_state_t;

  logic [31:0] ms_div;
  logic ms_tick;
  logic [MS_W-1:0] cnt;
  logic [MS_W-1:0] gap;
  host_state_t state;
  logic rail_s1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ms_div <= 32'h0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == 32'(MS_CYCLES - 1));
      ms_div <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_div + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rail_s1 <= 1'b0;
      module_rail_up <= 1'b0;
    end else begin
      rail_s1 <= pins.io_rail_output;
      module_rail_up <= rail_s1;
    end
  end

  // ****************************************
  // Pulse sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= H_SETTLE;
      cnt <= MS_W'(SUPPLY_SETTLE_MS);
      gap <= '0;
      pins.power_key_line_n <= 1'b1;
      pins.reset_line_n <= 1'b1;
    end else begin
      if (ms_tick && cnt != '0) cnt <= cnt - 1'b1;
      unique case (state)
        H_SETTLE: if (cnt == '0) state <= H_IDLE;
        H_IDLE: begin
          if (req_power_on || req_power_off) begin
            state <= H_PULSE;
            pins.power_key_line_n <= 1'b0;
            cnt <= req_power_on ? MS_W'(KEY_ON_HOLD_MS) : MS_W'(KEY_OFF_HOLD_MS);
            gap <= req_power_on ? MS_W'(BOOT_MS + GAP_MARGIN_MS) : MS_W'(SHUTDOWN_MS + GAP_MARGIN_MS);
          end else if (req_reset) begin
            state <= H_PULSE;
            pins.reset_line_n <= 1'b0;
            cnt <= MS_W'(RESET_HOLD_MS);
            // Restart after reset outlasts the reset spacing; wait for the longer
            gap <= MS_W'((BOOT_MS > RESET_GAP_MS ? BOOT_MS : RESET_GAP_MS) + GAP_MARGIN_MS);
          end
        end
        H_PULSE: if (cnt == '0) begin
          state <= H_WAIT;
          pins.power_key_line_n <= 1'b1;
          pins.reset_line_n <= 1'b1;
          cnt <= gap;
        end
        H_WAIT: if (cnt == '0) state <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b1;
      pins.power_on_level_line <= 1'b0;
    end else begin
      busy <= (state != H_IDLE);
      pins.power_on_level_line <= level_hold;
    end
  end
endmodule

// >>> test/pwr_pins_chk.sv
/*
  Checker on the pins between the host and module ends.
  Assumes one clock and an instance beside the interface.
*/
`timescale 1ns/1ps
module pwr_pins_chk #(
  parameter int MS_CYCLES = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic power_key_line_n,
  input wire logic power_on_level_line,
  input wire logic reset_line_n,
  input wire logic io_rail_output,
  input wire logic link_state_indicator
);
  localparam int M = MS_CYCLES;
  int key_len, rst_len, lvl_len, up_cnt, boot_cnt, sd_cnt, gap_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Run lengths
  // ****************************************
  // Gap starts at 32'h3FFF_FFFF, far above 20000*M, so the first reset is legal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_len <= 0;
      rst_len <= 0;
      lvl_len <= 0;
      up_cnt <= 0;
      boot_cnt <= 0;
      sd_cnt <= 0;
      gap_cnt <= 32'h3FFF_FFFF;
    end else begin
      key_len <= power_key_line_n ? 0 : key_len + 1;
      rst_len <= reset_line_n ? 0 : rst_len + 1;
      lvl_len <= power_on_level_line ? lvl_len + 1 : 0;
      up_cnt <= up_cnt + 1;
      boot_cnt <= ($rose(io_rail_output) || ($rose(reset_line_n) && io_rail_output)) ? 0 : boot_cnt + 1;
      sd_cnt <= ($rose(power_key_line_n) && io_rail_output) ? 0 : sd_cnt + 1;
      gap_cnt <= $fell(reset_line_n) ? 0 : gap_cnt + 1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_key_len;
    $rose(power_key_line_n) |-> (io_rail_output ? (key_len >= 3000*M && key_len <= 7000*M)
      : (key_len >= 1600*M && key_len <= 3000*M));
  endproperty
  a_key_len: assert property (p_key_len) else $error("key pulse length out of window");
  property p_rail_up;
    $rose(power_key_line_n) && !io_rail_output && key_len >= 1600*M && key_len <= 3000*M |-> ##[1:10] io_rail_output;
  endproperty
  a_rail_up: assert property (p_rail_up) else $error("rail did not rise after key pulse");
  property p_rail_down;
    $fell(io_rail_output) |-> sd_cnt >= 6000*M - M && sd_cnt <= 6000*M + M + 10;
  endproperty
  a_rail_down: assert property (p_rail_down) else $error("rail dropped at wrong time");
  property p_rst_len;
    $rose(reset_line_n) |-> rst_len >= 500*M && rst_len <= 3000*M;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length out of window");
  property p_settle;
    $fell(power_key_line_n) |-> up_cnt >= 30*M;
  endproperty
  a_settle: assert property (p_settle) else $error("key pressed too soon after supply");
  property p_quiet;
    io_rail_output && boot_cnt < 40000*M |-> power_key_line_n && reset_line_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin activity during start-up");
  property p_gap;
    $fell(reset_line_n) |-> gap_cnt >= 20000*M;
  endproperty
  a_gap: assert property (p_gap) else $error("resets too close together");
  property p_lvl_late;
    lvl_len == 1202*M + 10 |-> io_rail_output;
  endproperty
  a_lvl_late: assert property (p_lvl_late) else $error("level line did not power on");
  property p_lvl_early;
    $rose(io_rail_output) && power_on_level_line |-> lvl_len > 1200*M;
  endproperty
  a_lvl_early: assert property (p_lvl_early) else $error("level line powered on too early");
  property p_ind_dark;
    !io_rail_output |-> !link_state_indicator;
  endproperty
  a_ind_dark: assert property (p_ind_dark) else $error("indicator lit while unpowered");
endmodule

// >>> test/test_module_power_reset_status.sv
/*
  Bench joining host and module ends through the pin interface.
  Assumes MS_CYCLES of 1, so one millisecond is one clock.
*/
`timescale 1ns/1ps
module test_module_power_reset_status;
  import pwr_seq_pkg::*;
  localparam int M = 1;
  logic sys_clk, rst, req_power_on, req_power_off, req_reset, level_hold;
  logic soft_reset_cmd, soft_shutdown_cmd, busy, module_rail_up, powered, ready, in_reset;
  ind_mode_t ind_mode;
  int errors, checks_done, cyc, t;
  pwr_ctrl_if pins();
  host_power_controller #(.MS_CYCLES(M)) host_power_controller_inst (.sys_clk(sys_clk), .rst(rst),
    .req_power_on(req_power_on), .req_power_off(req_power_off), .req_reset(req_reset),
    .level_hold(level_hold), .busy(busy), .module_rail_up(module_rail_up), .pins(pins));
  module_power_reset_status #(.MS_CYCLES(M)) module_power_reset_status_inst (.sys_clk(sys_clk), .rst(rst),
    .pins(pins), .soft_reset_cmd(soft_reset_cmd), .soft_shutdown_cmd(soft_shutdown_cmd),
    .ind_mode(ind_mode), .powered(powered), .ready(ready), .in_reset(in_reset));
  pwr_pins_chk #(.MS_CYCLES(M)) pwr_pins_chk_inst (.sys_clk(sys_clk), .rst(rst),
    .power_key_line_n(pins.power_key_line_n), .power_on_level_line(pins.power_on_level_line),
    .reset_line_n(pins.reset_line_n), .io_rail_output(pins.io_rail_output),
    .link_state_indicator(pins.link_state_indicator));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string what, int lo, int hi, int seen);
    checks_done++;
    if (seen < lo || seen > hi) begin
      errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  function automatic logic sig(int s);
    case (s)
      0: return ready;
      1: return pins.io_rail_output;
      2: return in_reset;
      3: return pins.link_state_indicator;
      default: return busy;
    endcase
  endfunction
  // Sampled on the falling edge, clear of the launch edge
  task automatic wait_sig(int s, logic v, int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic pulse(int which);
    wait_sig(4, 1'b0, 50000*M, t);
    @(posedge sys_clk);
    case (which)
      0: req_power_on <= 1'b1;
      1: req_power_off <= 1'b1;
      default: req_reset <= 1'b1;
    endcase
    @(posedge sys_clk);
    {req_power_on, req_power_off, req_reset} <= 3'h0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_key_on;
    pulse(0);
    wait_sig(4, 1'b1, 4, t);
    check("busy raised", 1, 2, t);
    wait_sig(1, 1'b1, 3000*M, t);
    check("rail up", 2000*M, 2000*M+12, t);
    wait_sig(0, 1'b1, 41000*M, t);
    check("boot time", 40000*M-2, 40000*M+M+4, t);
    check("powered", 1, 1, int'(powered === 1'b1));
    check("host sees rail", 1, 1, int'(module_rail_up === 1'b1));
    $display("test key_on done");
  endtask
  task automatic t_blink(ind_mode_t m, int a, int b);
    @(posedge sys_clk);
    ind_mode <= m;
    wait_sig(3, 1'b0, 4000*M, t);
    wait_sig(3, 1'b1, 4000*M, t);
    wait_sig(3, 1'b0, 4000*M, t);
    check("high phase", a*M-2, a*M+2, t);
    wait_sig(3, 1'b1, 4000*M, t);
    check("low phase", b*M-2, b*M+2, t);
    $display("test blink %0d done", m);
  endtask
  task automatic t_voice;
    int n;
    n = 0;
    @(posedge sys_clk);
    ind_mode <= IND_VOICE;
    repeat (8) @(negedge sys_clk);
    repeat (300) begin
      @(negedge sys_clk);
      n += (pins.link_state_indicator !== 1'b0);
    end
    check("voice steady low", 0, 0, n);
    $display("test voice done");
  endtask
  task automatic t_hw_reset;
    pulse(2);
    wait_sig(2, 1'b1, 2000*M, t);
    check("reset seen", 1000*M, 1000*M+12, t);
    check("ready in reset", 0, 0, int'(ready !== 1'b0));
    // Soft commands must be refused while restarting
    @(posedge sys_clk);
    {soft_reset_cmd, soft_shutdown_cmd} <= 2'h3;
    @(posedge sys_clk);
    {soft_reset_cmd, soft_shutdown_cmd} <= 2'h0;
    wait_sig(0, 1'b1, 41000*M, t);
    check("reboot time", 40000*M-2, 40000*M+M+4, t);
    $display("test hw_reset done");
  endtask
  task automatic t_off;
    pulse(1);
    wait_sig(1, 1'b0, 12000*M, t);
    check("rail off", 11000*M-2, 11000*M+M+12, t);
    check("powered off", 0, 0, int'(powered !== 1'b0));
    repeat (3) @(negedge sys_clk);
    check("host sees rail off", 0, 0, int'(module_rail_up !== 1'b0));
    $display("test off done");
  endtask
  task automatic t_level;
    @(posedge sys_clk);
    level_hold <= 1'b1;
    wait_sig(1, 1'b1, 2000*M, t);
    check("level on", 1200*M, 1202*M+12, t);
    repeat (20) @(posedge sys_clk);
    level_hold <= 1'b0;
    $display("test level done");
  endtask
  // ****************************************
  // Run control
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 110000) begin
      errors++;
      $display("mismatch timeout expected 0 seen 1");
      print_verdict();
    end
  end
  initial begin
    {rst, req_power_on, req_power_off, req_reset, level_hold} = 5'h10;
    {soft_reset_cmd, soft_shutdown_cmd} = 2'h0;
    ind_mode = IND_SEARCH;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_key_on();
    t_blink(IND_SEARCH, BLINK_SLOW_MS, BLINK_SLOW_MS);
    t_blink(IND_STANDBY, BLINK_LONG_MS, BLINK_SHORT_MS);
    t_blink(IND_DATA, BLINK_SHORT_MS, BLINK_SHORT_MS);
    t_voice();
    t_hw_reset();
    t_off();
    t_level();
    print_verdict();
  end
endmodule
